/* File: sfotp_pkg.sv */
// Contract
// - Three separately erasable 1024-byte auxiliary areas.
// - Erase frame: opcode 44H plus three address bytes.
// - Erase runs only if exactly 32 bits.
// - Valid erase starts timed cycle, busy meanwhile.
// - Each cycle clears the write latch flag.
// - Locked area ignores erase commands.
// - Locked area ignores program, contents unchanged.
// - Address: top byte zero, bits 15-12 select area.
// - Program frame: 42H, address, data bytes.
// - Program frame end starts timed cycle, busy meanwhile.
// - Each area holds four programming pages.
// - Read: 48H, address, dummy; sample rising edge.
// - Read data on falling edges, address increments.
// - Read offset wraps 3FFH to 000H.
// - Accepted reset aborts work, clears volatile state.
// - Reset needs 66H frame then 99H frame.
// - Reset recovery interval rejects all commands.
// - Reset opcodes accepted in both clock modes.
// - Opcode 5AH reads the parameter table.
// - Suspend states block auxiliary erase/program; program is blocked only when i_suspend_kind_flags[1] is set.
package sfotp_pkg;
    localparam logic [7:0] OP_WRITE_PERMIT = 8'h06;
    localparam logic [7:0] OP_WRITE_FORBID = 8'h04;
    localparam logic [7:0] OP_AUX_ERASE = 8'h44;
    localparam logic [7:0] OP_AUX_PROG = 8'h42;
    localparam logic [7:0] OP_AUX_READ = 8'h48;
    localparam logic [7:0] OP_RESET_EN = 8'h66;
    localparam logic [7:0] OP_RESET = 8'h99;
    localparam logic [7:0] OP_PARAM_READ = 8'h5a;
    localparam int AREA_BYTES = 1024;
    localparam int AREA_COUNT = 3;
    localparam int PAGE_BYTES = 256;
    localparam logic [15:0] BITS_OPCODE = 16'h0008;
    localparam logic [15:0] BITS_ADDR_END = 16'h0020;
    localparam logic [15:0] BITS_DATA_START = 16'h0028;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam int CLK_PERIOD_NS = 10;
    localparam int ERASE_CYCLE_TIME_NS = 100000;
    localparam int PROGRAM_CYCLE_TIME_NS = 50000;
    localparam int RESET_RECOVERY_NS = 30000;
    localparam int ERASE_CYCLES = (ERASE_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROGRAM_CYCLES = (PROGRAM_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_CYCLES = (RESET_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PARAM_ROM_BYTES = 16;
    localparam logic [127:0] PARAM_ROM = 128'hffff_ffff_ffff_ffff_ff01_0100_5044_4653;
    typedef enum logic [1:0] {SFOTP_IDLE, SFOTP_ERASE, SFOTP_PROG, SFOTP_RECOVER} sfotp_state_t;
endpackage

/* File: sfotp_core.sv */
`timescale 1ns/1ns
module sfotp_core #(
    parameter int ERASE_CYCLE_COUNT = sfotp_pkg::ERASE_CYCLES,
    parameter int PROGRAM_CYCLE_COUNT = sfotp_pkg::PROGRAM_CYCLES
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_si,
    output logic o_so,
    output logic o_so_oe,
    input wire logic [2:0] i_otp_lock_bits,
    input wire logic [1:0] i_suspend_kind_flags,
    output logic o_cycle_active_flag,
    output logic o_write_latch_flag,
    output logic o_volatile_clear
);
    import sfotp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Storage shared by both domains.

    logic [7:0] mem_r [0:AREA_COUNT*AREA_BYTES-1];
    logic [7:0] pbuf_r [0:PAGE_BYTES-1];
    logic [PAGE_BYTES-1:0] pvalid_r;
    logic busy_r;

    function automatic logic addr_ok(input logic [23:0] a);
        addr_ok = (a[23:16] == 8'h00) && (a[15:14] == 2'h0) && (a[11:10] == 2'h0) && (a[13:12] != 2'h0);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Link domain, rising edge: command, address and data capture.

    logic in_frame_r;
    logic frame_tgl_r;
    logic [15:0] cnt_r;
    logic [2:0] bitpos_r;
    logic [6:0] shift_r;
    logic [7:0] opcode_r;
    logic [23:0] addr_r;
    logic [7:0] pg_idx_r;
    logic rd_ok_r;
    logic rd_param_r;
    logic bsy_s1_r;
    logic bsy_s2_r;
    logic [15:0] cnt_nxt;
    logic [2:0] bitpos_nxt;
    logic [7:0] sh_nxt;
    logic byte_done;

    always_comb begin
        cnt_nxt = in_frame_r ? ((cnt_r == 16'hffff) ? cnt_r : cnt_r + 16'h0001) : 16'h0001;
        bitpos_nxt = in_frame_r ? bitpos_r + 3'h1 : 3'h1;
        sh_nxt = {in_frame_r ? shift_r : 7'h00, i_si};
        byte_done = (bitpos_nxt == 3'h0);
    end

    // Chip select high ends the frame without any clock edge, so this flag and the output enable clear asynchronously.
    always_ff @(posedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            in_frame_r <= 1'b0;
        end else begin
            in_frame_r <= 1'b1;
        end
    end

    // Every bit is taken on the rising edge, which holds in clock mode 0 and mode 3 alike.
    always_ff @(posedge i_sck) begin
        cnt_r <= cnt_nxt;
        bitpos_r <= bitpos_nxt;
        shift_r <= sh_nxt[6:0];
        bsy_s1_r <= busy_r;
        bsy_s2_r <= bsy_s1_r;
    end

    // The frame toggle flips once per frame. A mode 3 host lifts the clock while still deselected, and that edge
    // must not count, or the frame's own first edge would undo it and the frame would be lost.
    // Its reset is the system reset, which is applied while the serial clock stands still.
    always_ff @(posedge i_sck or posedge i_rst) begin
        if (i_rst) begin
            frame_tgl_r <= 1'b0;
        end else if (!in_frame_r && !i_cs_n) begin
            frame_tgl_r <= ~frame_tgl_r;
        end
    end

    always_ff @(posedge i_sck) begin
        if (byte_done && cnt_nxt == BITS_OPCODE) begin
            opcode_r <= sh_nxt;
        end
        if (byte_done && cnt_nxt > BITS_OPCODE && cnt_nxt <= BITS_ADDR_END) begin
            addr_r <= {addr_r[15:0], sh_nxt};
        end
    end

    // A read is admitted once its address is complete; it stays silent while the device is busy.
    always_ff @(posedge i_sck) begin
        if (!in_frame_r) begin
            rd_ok_r <= 1'b0;
            rd_param_r <= 1'b0;
        end else if (byte_done && cnt_nxt == BITS_ADDR_END) begin
            rd_ok_r <= !bsy_s2_r && opcode_r == OP_AUX_READ && addr_ok({addr_r[15:0], sh_nxt});
            rd_param_r <= !bsy_s2_r && opcode_r == OP_PARAM_READ;
        end
    end

    // Data bytes fill a page buffer; the index is eight bits so it wraps inside the page.
    always_ff @(posedge i_sck) begin
        if (!in_frame_r) begin
            pvalid_r <= '0;
        end else if (byte_done && cnt_nxt == BITS_ADDR_END) begin
            pg_idx_r <= sh_nxt;
        end else if (byte_done && cnt_nxt >= BITS_DATA_START && opcode_r == OP_AUX_PROG) begin
            pbuf_r[pg_idx_r] <= sh_nxt;
            pvalid_r[pg_idx_r] <= 1'b1;
            pg_idx_r <= pg_idx_r + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Link domain, falling edge: serial output.

    logic [23:0] raddr_r;
    logic [6:0] out_sh_r;
    logic so_r;
    logic so_oe_r;
    logic [23:0] rd_cur;
    logic [7:0] rd_byte;
    logic rd_active;

    always_comb begin
        // Outside a frame the read stays off, so the first falling edge of a mode 3 frame cannot drive stale data.
        rd_active = in_frame_r && (rd_ok_r || rd_param_r) && cnt_r >= BITS_DATA_START;
        rd_cur = (cnt_r == BITS_DATA_START) ? addr_r : raddr_r;
        rd_byte = ERASED_BYTE;
        if (rd_param_r) begin
            if (rd_cur < 24'(PARAM_ROM_BYTES)) begin
                rd_byte = PARAM_ROM[{rd_cur[3:0], 3'h0} +: 8];
            end
        end else begin
            rd_byte = mem_r[{rd_cur[13:12] - 2'h1, rd_cur[9:0]}];
        end
    end

    always_ff @(negedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            so_oe_r <= 1'b0;
        end else begin
            so_oe_r <= rd_active;
        end
    end

    // The memory is only read here while no cycle can write it, since reads are refused when busy.
    always_ff @(negedge i_sck) begin
        if (rd_active && bitpos_r == 3'h0) begin
            so_r <= rd_byte[7];
            out_sh_r <= rd_byte[6:0];
            raddr_r <= {rd_cur[23:10], rd_cur[9:0] + 10'h001};
        end else begin
            so_r <= out_sh_r[6];
            out_sh_r <= {out_sh_r[5:0], 1'b0};
        end
    end

    assign o_so = so_r;
    assign o_so_oe = so_oe_r;

    ////////////////////////////////////////////////////////////////////////////////
    // System domain: frame end detection and command decode.

    logic cs_s1_r;
    logic cs_s2_r;
    logic cs_s3_r;
    logic tgl_s1_r;
    logic tgl_s2_r;
    logic seen_r;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_s3_r <= 1'b1;
            tgl_s1_r <= 1'b0;
            tgl_s2_r <= 1'b0;
            seen_r <= 1'b0;
        end else begin
            cs_s1_r <= i_cs_n;
            cs_s2_r <= cs_s1_r;
            cs_s3_r <= cs_s2_r;
            tgl_s1_r <= frame_tgl_r;
            tgl_s2_r <= tgl_s1_r;
            if (cs_s2_r && !cs_s3_r) begin
                seen_r <= tgl_s2_r;
            end
        end
    end

    // The frame summary is read only after chip select has risen, when the serial clock stands still.
    logic fend;
    logic [1:0] area_idx;
    logic lock_hit;
    logic is_byte_cmd;
    logic ok_erase;
    logic ok_prog;
    logic rst_en;
    logic rst_go;
    logic armed_r;
    sfotp_state_t st_r;
    logic [31:0] timer_r;
    logic wel_r;
    logic vclr_r;

    always_comb begin
        fend = cs_s2_r && !cs_s3_r && (tgl_s2_r != seen_r);
        area_idx = addr_r[13:12] - 2'h1;
        lock_hit = i_otp_lock_bits[area_idx];
        is_byte_cmd = fend && cnt_r == BITS_OPCODE;
        ok_erase = fend && opcode_r == OP_AUX_ERASE && cnt_r == BITS_ADDR_END && addr_ok(addr_r)
            && wel_r && !lock_hit && i_suspend_kind_flags == 2'h0;
        ok_prog = fend && opcode_r == OP_AUX_PROG && cnt_r >= BITS_DATA_START && (|pvalid_r) && addr_ok(addr_r)
            && wel_r && !lock_hit && !i_suspend_kind_flags[1];
        rst_en = is_byte_cmd && opcode_r == OP_RESET_EN;
        rst_go = is_byte_cmd && opcode_r == OP_RESET && armed_r;
    end

    // Any complete frame other than the enable cancels a pending enable.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            armed_r <= 1'b0;
        end else if (fend) begin
            armed_r <= rst_en && st_r != SFOTP_RECOVER;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // System domain: cycle sequencer.

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            st_r <= SFOTP_IDLE;
            timer_r <= 32'h0;
            busy_r <= 1'b0;
            vclr_r <= 1'b0;
        end else begin
            vclr_r <= 1'b0;
            if (rst_go && st_r != SFOTP_RECOVER) begin
                st_r <= SFOTP_RECOVER;
                timer_r <= 32'(RESET_CYCLES - 1);
                busy_r <= 1'b1;
                vclr_r <= 1'b1;
            end else begin
                unique case (st_r)
                    SFOTP_IDLE: begin
                        if (ok_erase) begin
                            st_r <= SFOTP_ERASE;
                            timer_r <= 32'(ERASE_CYCLE_COUNT - 1);
                            busy_r <= 1'b1;
                        end else if (ok_prog) begin
                            st_r <= SFOTP_PROG;
                            timer_r <= 32'(PROGRAM_CYCLE_COUNT - 1);
                            busy_r <= 1'b1;
                        end
                    end
                    SFOTP_ERASE, SFOTP_PROG, SFOTP_RECOVER: begin
                        if (timer_r == 32'h0) begin
                            st_r <= SFOTP_IDLE;
                            busy_r <= 1'b0;
                        end else begin
                            timer_r <= timer_r - 32'h1;
                        end
                    end
                endcase
            end
        end
    end

    // The latch drops as the cycle starts, well before it completes.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            wel_r <= 1'b0;
        end else if (rst_go || ok_erase || ok_prog) begin
            wel_r <= 1'b0;
        end else if (st_r == SFOTP_IDLE && is_byte_cmd && opcode_r == OP_WRITE_PERMIT) begin
            wel_r <= 1'b1;
        end else if (st_r == SFOTP_IDLE && is_byte_cmd && opcode_r == OP_WRITE_FORBID) begin
            wel_r <= 1'b0;
        end
    end

    // Contents change when the cycle is accepted, so the page buffer is free for the next frame.
    // A reset during the cycle cannot undo this, matching the warned-of corruption.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            for (int i = 0; i < AREA_COUNT * AREA_BYTES; i++) begin
                mem_r[i] <= ERASED_BYTE;
            end
        end else if (st_r == SFOTP_IDLE && !rst_go && ok_erase) begin
            for (int i = 0; i < AREA_BYTES; i++) begin
                mem_r[{area_idx, 10'(i)}] <= ERASED_BYTE;
            end
        end else if (st_r == SFOTP_IDLE && !rst_go && ok_prog) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (pvalid_r[i]) begin
                    mem_r[{area_idx, addr_r[9:8], 8'(i)}] <= mem_r[{area_idx, addr_r[9:8], 8'(i)}] & pbuf_r[i];
                end
            end
        end
    end

    assign o_cycle_active_flag = busy_r;
    assign o_write_latch_flag = wel_r;
    assign o_volatile_clear = vclr_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    a_erase_starts: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (st_r == SFOTP_IDLE && ok_erase && !rst_go) |=> (busy_r && st_r == SFOTP_ERASE) [*2])
        else $error("valid erase did not start a busy erase cycle");
    a_erase_length: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (st_r == SFOTP_IDLE && fend && opcode_r == OP_AUX_ERASE && cnt_r != BITS_ADDR_END) |=> !busy_r)
        else $error("erase frame of wrong length started a cycle");
    a_cycle_latch: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        $rose(busy_r) |-> !wel_r)
        else $error("write latch still set after cycle start");
    a_lock_erase: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (st_r == SFOTP_IDLE && fend && opcode_r == OP_AUX_ERASE && lock_hit) |=> !busy_r)
        else $error("erase of locked area started a cycle");
    a_lock_prog: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (st_r == SFOTP_IDLE && fend && opcode_r == OP_AUX_PROG && lock_hit) |=> !busy_r)
        else $error("program of locked area started a cycle");
    a_prog_starts: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (st_r == SFOTP_IDLE && ok_prog && !rst_go) |=> busy_r ##1 (st_r == SFOTP_PROG))
        else $error("valid program did not start a program cycle");
    a_no_latch: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (st_r == SFOTP_IDLE && fend && !wel_r && (opcode_r == OP_AUX_ERASE || opcode_r == OP_AUX_PROG)) |=> !busy_r)
        else $error("erase or program without write latch started a cycle");
    a_suspend_block: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (st_r == SFOTP_IDLE && fend && opcode_r == OP_AUX_ERASE && i_suspend_kind_flags != 2'h0) |=> !busy_r)
        else $error("erase accepted while suspended");
    a_reset_clear: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (rst_go && st_r != SFOTP_RECOVER) |=> (vclr_r && !wel_r && st_r == SFOTP_RECOVER) ##1 !vclr_r)
        else $error("accepted reset did not clear state and enter recovery");
    a_recover_reject: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (st_r == SFOTP_RECOVER && timer_r != 32'h0) |=> !wel_r && busy_r)
        else $error("command accepted during reset recovery");
    a_reset_unarmed: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (is_byte_cmd && opcode_r == OP_RESET && !armed_r) |=> !vclr_r)
        else $error("reset accepted without preceding enable");
    a_cycle_ends: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (st_r != SFOTP_IDLE && timer_r == 32'h0 && !rst_go) |=> (!busy_r && st_r == SFOTP_IDLE))
        else $error("timed cycle did not end when its count ran out");
    a_busy_latch: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (st_r != SFOTP_IDLE) |=> !wel_r)
        else $error("write latch set while a cycle runs");
    a_vclr_pulse: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        vclr_r |=> !vclr_r)
        else $error("volatile clear pulse longer than one cycle");
    a_oe_release: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_cs_n |-> !so_oe_r)
        else $error("serial output driven while deselected");
    a_recover_arm: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (st_r == SFOTP_RECOVER) |=> !armed_r)
        else $error("reset enable armed during recovery");

    c_erase: cover property (@(posedge i_clk_sys) disable iff (i_rst) st_r == SFOTP_IDLE && ok_erase);
    c_prog: cover property (@(posedge i_clk_sys) disable iff (i_rst) st_r == SFOTP_IDLE && ok_prog);
    c_reset_seq: cover property (@(posedge i_clk_sys) disable iff (i_rst) rst_go);
    c_reset_abort: cover property (@(posedge i_clk_sys) disable iff (i_rst) rst_go && st_r == SFOTP_ERASE);
    c_read: cover property (@(posedge i_clk_sys) disable iff (i_rst) so_oe_r);
endmodule

/* File: sfotp_host.sv */
`timescale 1ns/1ns
module sfotp_host (
    output logic o_cs_n,
    output logic o_sck,
    output logic o_si,
    input wire logic i_so,
    input wire logic i_so_oe
);
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_si = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // One framed transfer, MSB first, clock standing still between frames.
    // Bits sent past nbits toggle so that a stale line never looks like data.
    task automatic xfer(input logic [63:0] tx, input int nbits, input int nrd, input logic mode3,
                        output logic [31:0] rx);
        rx = 32'h0;
        o_sck = mode3;
        #10;
        o_cs_n = 1'b0;
        #10;
        for (int i = 0; i < nbits + 8 * nrd; i++) begin
            o_sck = 1'b0;
            o_si = (i < nbits) ? tx[63 - i] : ~o_si;
            #7;
            o_sck = 1'b1;
            if (i >= nbits) begin
                rx = {rx[30:0], i_so_oe ? i_so : 1'bx};
            end
            #8;
        end
        o_sck = mode3;
        #5;
        o_cs_n = 1'b1;
        o_si = ~o_si;
        #60;
    endtask
endmodule

/* File: sfotp_core_tb.sv */
`timescale 1ns/1ns
module sfotp_core_tb;
    import sfotp_pkg::*;
    // Short cycle counts keep the run brief; the two differ so a swap shows.
    localparam int ECNT = 24;
    localparam int PCNT = 20;
    logic i_clk_sys, i_rst, sck, cs_n, si, so, so_oe, busy, latch, vclr;
    logic [2:0] lock;
    logic [1:0] susp;
    logic [31:0] rx;
    int failures, check_count, cyc, run_len, last_len, clr_cnt, n;

    sfotp_core #(.ERASE_CYCLE_COUNT(ECNT), .PROGRAM_CYCLE_COUNT(PCNT)) sfotp_core_inst (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_sck(sck), .i_cs_n(cs_n), .i_si(si),
        .o_so(so), .o_so_oe(so_oe), .i_otp_lock_bits(lock), .i_suspend_kind_flags(susp),
        .o_cycle_active_flag(busy), .o_write_latch_flag(latch), .o_volatile_clear(vclr));
    sfotp_host sfotp_host_inst (.o_cs_n(cs_n), .o_sck(sck), .o_si(si), .i_so(so), .i_so_oe(so_oe));

    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    ////////////////////////////////////////////////////////////////
    // Busy runs are measured here because busy rises before a frame task returns.
    always @(posedge i_clk_sys) begin
        cyc <= cyc + 1;
        if (vclr === 1'b1) begin
            clr_cnt <= clr_cnt + 1;
        end
        if (busy === 1'b1) begin
            run_len <= run_len + 1;
        end else if (run_len != 0) begin
            last_len <= run_len;
            run_len <= 0;
        end
        if (cyc == 20000) begin
            failures++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_cnt(input int got, input int exp);
        check_count++;
        if (got != exp) begin
            failures++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge i_clk_sys);
        #1;
    endtask
    task automatic cmd(input logic [7:0] op, input logic m3);
        sfotp_host_inst.xfer({op, 56'h0}, 8, 0, m3, rx);
    endtask
    task automatic rd(input logic [7:0] op, input logic [23:0] a, input int nr);
        sfotp_host_inst.xfer({op, a, 32'h0}, 40, nr, 1'b0, rx);
    endtask
    task automatic wait_done;
        tick(1);
        for (int i = 0; i < 4000 && busy !== 1'b0; i++) begin
            tick(1);
        end
        tick(2);
        n = last_len;
        last_len = 0;
    endtask
    // Every write is preceded by its own permit so a refusal never leaks into the next case.
    task automatic wr(input logic [63:0] tx, input int nb);
        cmd(OP_WRITE_PERMIT, 1'b0);
        sfotp_host_inst.xfer(tx, nb, 0, 1'b0, rx);
        wait_done();
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_program;
        sfotp_host_inst.xfer({OP_AUX_ERASE, 24'h001000, 32'h0}, 32, 0, 1'b0, rx);
        wait_done();
        chk_cnt(n, 0);
        cmd(OP_WRITE_PERMIT, 1'b0);
        chk_flag(latch, 1'b1);
        wr({OP_AUX_PROG, 24'h0010fe, 24'h5a3c12, 8'h0}, 56);
        chk_cnt(n, PCNT);
        chk_flag(latch, 1'b0);
        wr({OP_AUX_PROG, 24'h003200, 8'ha5, 24'h0}, 40);
        rd(OP_AUX_READ, 24'h0010fe, 3);
        chk_data(rx, 32'h005a3cff);
        rd(OP_AUX_READ, 24'h0013ff, 2);
        chk_data(rx, 32'h0000ff12);
    endtask
    task automatic t_erase;
        logic [23:0] ad [5] = '{24'h000000, 24'h001400, 24'h011000, 24'h001000, 24'h001000};
        int nb [5] = '{32, 32, 32, 31, 33};
        foreach (ad[i]) begin
            wr({OP_AUX_ERASE, ad[i], 32'h0}, nb[i]);
            chk_cnt(n, 0);
        end
        wr({OP_AUX_ERASE, 24'h0013ff, 32'h0}, 32);
        chk_cnt(n, ECNT);
        chk_flag(latch, 1'b0);
        rd(OP_AUX_READ, 24'h0010ff, 2);
        chk_data(rx, 32'h0000ffff);
        rd(OP_AUX_READ, 24'h003200, 1);
        chk_data(rx, 32'h000000a5);
    endtask
    task automatic t_guards;
        tick(1);
        lock = 3'b100;
        wr({OP_AUX_PROG, 24'h003200, 8'h00, 24'h0}, 40);
        chk_cnt(n, 0);
        wr({OP_AUX_ERASE, 24'h003000, 32'h0}, 32);
        chk_cnt(n, 0);
        rd(OP_AUX_READ, 24'h003200, 1);
        chk_data(rx, 32'h000000a5);
        lock = 3'b000;
        susp = 2'b10;
        wr({OP_AUX_PROG, 24'h001010, 8'h0f, 24'h0}, 40);
        chk_cnt(n, 0);
        wr({OP_AUX_ERASE, 24'h001000, 32'h0}, 32);
        chk_cnt(n, 0);
        susp = 2'b01;
        wr({OP_AUX_ERASE, 24'h001000, 32'h0}, 32);
        chk_cnt(n, 0);
        wr({OP_AUX_PROG, 24'h001010, 8'h0f, 24'h0}, 40);
        chk_cnt(n, PCNT);
        susp = 2'b00;
    endtask
    task automatic t_reset;
        cmd(OP_WRITE_PERMIT, 1'b0);
        chk_flag(busy, 1'b0);
        cmd(OP_RESET_EN, 1'b1);
        cmd(OP_RESET, 1'b1);
        chk_cnt(clr_cnt, 1);
        chk_flag(latch, 1'b0);
        cmd(OP_WRITE_PERMIT, 1'b0);
        chk_flag(latch, 1'b0);
        wait_done();
        chk_cnt(n, RESET_CYCLES);
        cmd(OP_RESET, 1'b0);
        cmd(OP_RESET_EN, 1'b0);
        cmd(OP_WRITE_PERMIT, 1'b0);
        cmd(OP_RESET, 1'b0);
        wait_done();
        chk_cnt(clr_cnt, 1);
        cmd(OP_RESET_EN, 1'b0);
        cmd(OP_RESET, 1'b0);
        wait_done();
        chk_cnt(clr_cnt, 2);
        rd(OP_PARAM_READ, 24'h000000, 4);
        chk_data(rx, 32'h53464450);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        i_rst = 1'b1;
        lock = 3'b000;
        susp = 2'b00;
        tick(6);
        i_rst = 1'b0;
        tick(4);
        t_program();
        t_erase();
        t_guards();
        t_reset();
        end_of_test();
    end
endmodule
